// [include/adcc_pkg.sv]
package adcc_pkg;

  // peripheral clock and analog warm-up timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int WARMUP_NS = 1000;
  localparam int WARMUP_CYCLES = (WARMUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register indices, byte address is four times the index
  localparam logic [4:0] IDX_CONTROL_A = 5'h00;
  localparam logic [4:0] IDX_CLOCK_DIVIDER_CONTROL = 5'h01;
  localparam logic [4:0] IDX_REFERENCE_CONTROL = 5'h02;
  localparam logic [4:0] IDX_WINDOW_CONTROL = 5'h03;
  localparam logic [4:0] IDX_IRQ_ENABLE = 5'h04;
  localparam logic [4:0] IDX_IRQ_FLAGS = 5'h05;
  localparam logic [4:0] IDX_CONVERTER_STATUS = 5'h06;
  localparam logic [4:0] IDX_DEBUG_CONTROL = 5'h07;
  localparam logic [4:0] IDX_SAMPLE_DURATION = 5'h08;
  localparam logic [4:0] IDX_SAMPLING_CONFIG = 5'h09;
  localparam logic [4:0] IDX_CONVERSION_COMMAND = 5'h0A;
  localparam logic [4:0] IDX_AMPLIFIER_CONTROL = 5'h0B;
  localparam logic [4:0] IDX_POSITIVE_INPUT_SELECT = 5'h0C;
  localparam logic [4:0] IDX_NEGATIVE_INPUT_SELECT = 5'h0D;
  localparam logic [4:0] IDX_CONVERSION_RESULT = 5'h10;
  localparam logic [4:0] IDX_LAST_SAMPLE = 5'h14;
  localparam logic [4:0] IDX_SCRATCH_BYTE_0 = 5'h18;
  localparam logic [4:0] IDX_SCRATCH_BYTE_1 = 5'h19;
  localparam logic [4:0] IDX_SCRATCH_BYTE_2 = 5'h1A;
  localparam logic [4:0] IDX_WINDOW_LOW_THRESHOLD = 5'h1C;
  localparam logic [4:0] IDX_WINDOW_HIGH_THRESHOLD = 5'h1E;

  // control A field positions and writable mask
  localparam int BIT_RUN_IN_STANDBY = 7;
  localparam int BIT_KEEP_ANALOG_POWERED = 5;
  localparam int BIT_ENABLE = 0;
  localparam logic [7:0] CONTROL_A_MASK = 8'hA1;

  // irq enable and irq flags bit positions
  localparam int FLG_RESULT_READY = 0;
  localparam int FLG_SAMPLE_READY = 1;
  localparam int FLG_WINDOW_MATCH = 2;
  localparam int FLG_RESULT_OVERWRITE = 3;
  localparam int FLG_SAMPLE_OVERWRITE = 4;
  localparam int FLG_TRIGGER_OVERRUN = 5;
  localparam int NUM_FLAGS = 6;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h00000000;

  // start field of the conversion command and window modes
  localparam logic [2:0] START_IMMEDIATE = 3'h1;
  localparam logic [2:0] START_ON_EVENT = 3'h2;
  localparam logic [2:0] WIN_BELOW = 3'h1;
  localparam logic [2:0] WIN_ABOVE = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;

  // converter clock ticks added to the sample duration per conversion
  localparam logic [8:0] CONV_BASE_TICKS = 9'h00C;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WARM = 2'b01,
    ST_CONV = 2'b11,
    ST_DONE = 2'b10
  } adcc_state_t;

  // divisor selected by the clock divider code
  function automatic logic [6:0] adcc_divisor(input logic [3:0] code);
    unique case (code)
      4'h0: adcc_divisor = 7'd2;
      4'h1: adcc_divisor = 7'd4;
      4'h2: adcc_divisor = 7'd6;
      4'h3: adcc_divisor = 7'd8;
      4'h4: adcc_divisor = 7'd10;
      4'h5: adcc_divisor = 7'd12;
      4'h6: adcc_divisor = 7'd14;
      4'h7: adcc_divisor = 7'd16;
      4'h8: adcc_divisor = 7'd20;
      4'h9: adcc_divisor = 7'd24;
      4'hA: adcc_divisor = 7'd28;
      4'hB: adcc_divisor = 7'd32;
      4'hC: adcc_divisor = 7'd40;
      4'hD: adcc_divisor = 7'd48;
      4'hE: adcc_divisor = 7'd56;
      4'hF: adcc_divisor = 7'd64;
    endcase
  endfunction

endpackage

// [core/adcc_clock_divider.sv]
`timescale 1ns/1ps
module adcc_clock_divider (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  input wire logic [3:0] divSelect,
  output logic tick
);
  import adcc_pkg::*;

  typedef struct packed {
    logic [6:0] count;
    logic tick;
  } adcc_div_t;

  adcc_div_t s_ff;
  adcc_div_t nxt_s;

  // one tick per divisor periods of the peripheral clock, held at zero when stopped
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (!run) begin
      nxt_s.count = 7'd0;
    end else if (s_ff.count >= adcc_divisor(divSelect) - 7'd1) begin
      nxt_s.count = 7'd0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.count = s_ff.count + 7'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;
endmodule // adcc_clock_divider

// [core/adcc_control_bank.sv]
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Contract
// - no standby run: finish conversion, start none
// - standby run: operate, request main clock
// - low latency off: power analog per conversion
// - low latency on: analog stays powered
// - converter clock runs only while converting
// - enable bit turns converter on, resets off
// - prescaler code selects peripheral clock divisor
// - irq flags clear on writing one
// - both bits: power kept in standby
module adcc_control_bank #(
  parameter int ADDR_W = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic startEvent,
  input wire logic standbySleep,
  input wire logic powerDown,
  input wire logic debugHalt,
  input wire logic [15:0] analogSample,
  output logic analogPowerOn,
  output logic mainClockRequest,
  output logic convClockRun,
  output logic conversionInProgress,
  output logic [2:0] refSelect,
  output logic [7:0] ampControl,
  output logic [7:0] posInputSelect,
  output logic [7:0] negInputSelect,
  output logic evResultReady,
  output logic evSampleReady,
  output logic evWindowMatch,
  output logic irq
);
  import adcc_pkg::*;

  if (ADDR_W < 7) begin : g_bad_addr_w
    $error("adcc_control_bank: ADDR_W must be at least 7");
  end

  typedef struct packed {
    logic [7:0] controlA;
    logic [3:0] divSel;
    logic [2:0] refSel;
    logic [3:0] winCtl;
    logic [NUM_FLAGS-1:0] irqEn;
    logic [NUM_FLAGS-1:0] irqFlags;
    logic runWhileHalted;
    logic [7:0] sampDur;
    logic [6:0] sampCfg;
    logic [7:0] command;
    logic [7:0] amp;
    logic [7:0] positive_input_select;
    logic [7:0] negative_input_select;
    logic [31:0] result;
    logic [15:0] sample;
    logic [7:0] scratch0;
    logic [7:0] scratch1;
    logic [7:0] scratch2;
    logic [15:0] winLow;
    logic [15:0] winHigh;
    adcc_state_t state;
    logic [8:0] count;
    logic resUnread;
    logic sampUnread;
    logic [2:0] trigSync;
    logic trigLevel;
    logic analogPwr;
    logic mainReq;
    logic evRes;
    logic evSamp;
    logic evWin;
    logic irq;
    logic convRun;
    logic busy;
    logic awRdy;
    logic wRdy;
    logic awGot;
    logic awOk;
    logic [4:0] awIdx;
    logic wGot;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic arRdy;
    logic rValid;
    logic [31:0] rData;
  } adcc_state_s_t;

  adcc_state_s_t s_ff;
  adcc_state_s_t nxt_s;
  logic convTick;

  // converter clock, running only while a conversion is under way
  adcc_clock_divider u_divider (
    .clk(clk),
    .nrst(nrst),
    .run(s_ff.state == ST_CONV),
    .divSelect(s_ff.divSel),
    .tick(convTick)
  );

  // register read mux, unmapped words and unused bits read zero
  function automatic logic [31:0] readWord(input logic [4:0] idx);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (idx)
      IDX_CONTROL_A: v[7:0] = s_ff.controlA;
      IDX_CLOCK_DIVIDER_CONTROL: v[3:0] = s_ff.divSel;
      IDX_REFERENCE_CONTROL: v[2:0] = s_ff.refSel;
      IDX_WINDOW_CONTROL: v[3:0] = s_ff.winCtl;
      IDX_IRQ_ENABLE: v[NUM_FLAGS-1:0] = s_ff.irqEn;
      IDX_IRQ_FLAGS: v[NUM_FLAGS-1:0] = s_ff.irqFlags;
      IDX_CONVERTER_STATUS: v[0] = s_ff.busy;
      IDX_DEBUG_CONTROL: v[0] = s_ff.runWhileHalted;
      IDX_SAMPLE_DURATION: v[7:0] = s_ff.sampDur;
      IDX_SAMPLING_CONFIG: v[6:0] = s_ff.sampCfg;
      IDX_CONVERSION_COMMAND: v[7:0] = s_ff.command;
      IDX_AMPLIFIER_CONTROL: v[7:0] = s_ff.amp;
      IDX_POSITIVE_INPUT_SELECT: v[7:0] = s_ff.positive_input_select;
      IDX_NEGATIVE_INPUT_SELECT: v[7:0] = s_ff.negative_input_select;
      IDX_CONVERSION_RESULT: v = s_ff.result;
      IDX_LAST_SAMPLE: v[15:0] = s_ff.sample;
      IDX_SCRATCH_BYTE_0: v[7:0] = s_ff.scratch0;
      IDX_SCRATCH_BYTE_1: v[7:0] = s_ff.scratch1;
      IDX_SCRATCH_BYTE_2: v[7:0] = s_ff.scratch2;
      IDX_WINDOW_LOW_THRESHOLD: v[15:0] = s_ff.winLow;
      IDX_WINDOW_HIGH_THRESHOLD: v[15:0] = s_ff.winHigh;
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction

  // window comparison on the new sample
  function automatic logic windowHit(input logic [3:0] ctl, input logic [15:0] val,
                                     input logic [15:0] lo, input logic [15:0] hi);
    logic hit;
    hit = 1'b0;
    unique case (ctl[2:0])
      WIN_BELOW: hit = (val < lo);
      WIN_ABOVE: hit = (val > hi);
      WIN_INSIDE: hit = (val > lo) && (val < hi);
      WIN_OUTSIDE: hit = (val < lo) || (val > hi);
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic doWrite;
  logic immStart;
  logic trigEdge;
  logic startReq;
  logic canStart;
  logic enabled;
  logic runStd;
  logic keep_analog_powered;
  logic [NUM_FLAGS-1:0] setFlags;
  logic [NUM_FLAGS-1:0] clrFlags;
  logic [15:0] newSample;
  logic [15:0] winSrc;

  // next state of the whole block
  always_comb begin
    nxt_s = s_ff;
    nxt_s.evRes = 1'b0;
    nxt_s.evSamp = 1'b0;
    nxt_s.evWin = 1'b0;
    setFlags = '0;
    clrFlags = '0;
    immStart = 1'b0;
    newSample = analogSample;
    winSrc = 16'h0000;
    enabled = s_ff.controlA[BIT_ENABLE];
    runStd = s_ff.controlA[BIT_RUN_IN_STANDBY];
    keep_analog_powered = s_ff.controlA[BIT_KEEP_ANALOG_POWERED];
    doWrite = s_ff.awGot && s_ff.wGot && !s_ff.bValid;

    // write address and data are taken independently
    if (s_axi_awvalid && s_ff.awRdy) begin
      nxt_s.awGot = 1'b1;
      nxt_s.awIdx = s_axi_awaddr[6:2];
      nxt_s.awOk = ((s_axi_awaddr >> 7) == '0);
    end
    if (s_axi_wvalid && s_ff.wRdy) begin
      nxt_s.wGot = 1'b1;
      nxt_s.wData = s_axi_wdata;
      nxt_s.wStrb = s_axi_wstrb;
    end

    // register write, byte lanes honoured, unused bits dropped
    if (doWrite) begin
      nxt_s.awGot = 1'b0;
      nxt_s.wGot = 1'b0;
      nxt_s.bValid = 1'b1;
      if (s_ff.awOk && s_ff.wStrb[0]) begin
        unique case (s_ff.awIdx)
          IDX_CONTROL_A: nxt_s.controlA = s_ff.wData[7:0] & CONTROL_A_MASK;
          IDX_CLOCK_DIVIDER_CONTROL: nxt_s.divSel = s_ff.wData[3:0];
          IDX_REFERENCE_CONTROL: nxt_s.refSel = s_ff.wData[2:0];
          IDX_WINDOW_CONTROL: nxt_s.winCtl = s_ff.wData[3:0];
          IDX_IRQ_ENABLE: nxt_s.irqEn = s_ff.wData[NUM_FLAGS-1:0];
          IDX_IRQ_FLAGS: clrFlags = s_ff.wData[NUM_FLAGS-1:0];
          IDX_DEBUG_CONTROL: nxt_s.runWhileHalted = s_ff.wData[0];
          IDX_SAMPLE_DURATION: nxt_s.sampDur = s_ff.wData[7:0];
          IDX_SAMPLING_CONFIG: nxt_s.sampCfg = s_ff.wData[6:0];
          IDX_CONVERSION_COMMAND: begin
            nxt_s.command = s_ff.wData[7:0];
            immStart = (s_ff.wData[2:0] == START_IMMEDIATE);
          end
          IDX_AMPLIFIER_CONTROL: nxt_s.amp = s_ff.wData[7:0];
          IDX_POSITIVE_INPUT_SELECT: nxt_s.positive_input_select = s_ff.wData[7:0];
          IDX_NEGATIVE_INPUT_SELECT: nxt_s.negative_input_select = s_ff.wData[7:0];
          IDX_SCRATCH_BYTE_0: nxt_s.scratch0 = s_ff.wData[7:0];
          IDX_SCRATCH_BYTE_1: nxt_s.scratch1 = s_ff.wData[7:0];
          IDX_SCRATCH_BYTE_2: nxt_s.scratch2 = s_ff.wData[7:0];
          IDX_WINDOW_LOW_THRESHOLD: nxt_s.winLow[7:0] = s_ff.wData[7:0];
          IDX_WINDOW_HIGH_THRESHOLD: nxt_s.winHigh[7:0] = s_ff.wData[7:0];
          default: ;
        endcase
      end
      if (s_ff.awOk && s_ff.wStrb[1]) begin
        if (s_ff.awIdx == IDX_WINDOW_LOW_THRESHOLD) begin
          nxt_s.winLow[15:8] = s_ff.wData[15:8];
        end
        if (s_ff.awIdx == IDX_WINDOW_HIGH_THRESHOLD) begin
          nxt_s.winHigh[15:8] = s_ff.wData[15:8];
        end
      end
    end
    if (s_ff.bValid && s_axi_bready) begin
      nxt_s.bValid = 1'b0;
    end
    nxt_s.awRdy = !nxt_s.awGot && !nxt_s.bValid;
    nxt_s.wRdy = !nxt_s.wGot && !nxt_s.bValid;

    // register read, a read of result or sample marks it as read
    if (s_axi_arvalid && s_ff.arRdy) begin
      nxt_s.rValid = 1'b1;
      nxt_s.rData = ((s_axi_araddr >> 7) == '0) ? readWord(s_axi_araddr[6:2]) : 32'h00000000;
      if ((s_axi_araddr >> 7) == '0 && s_axi_araddr[6:2] == IDX_CONVERSION_RESULT) begin
        nxt_s.resUnread = 1'b0;
      end
      if ((s_axi_araddr >> 7) == '0 && s_axi_araddr[6:2] == IDX_LAST_SAMPLE) begin
        nxt_s.sampUnread = 1'b0;
      end
    end
    if (s_ff.rValid && s_axi_rready) begin
      nxt_s.rValid = 1'b0;
    end
    nxt_s.arRdy = !nxt_s.rValid;

    // start event: three-stage synchroniser, level moves when stages two and three agree
    nxt_s.trigSync = {s_ff.trigSync[1:0], startEvent};
    if (s_ff.trigSync[2] == s_ff.trigSync[1]) begin
      nxt_s.trigLevel = s_ff.trigSync[2];
    end
    trigEdge = nxt_s.trigLevel && !s_ff.trigLevel;
    startReq = immStart || (trigEdge && s_ff.command[2:0] == START_ON_EVENT);

    // new conversions only when enabled, awake enough and not halted
    canStart = enabled && !powerDown
               && !(standbySleep && !runStd)
               && !(debugHalt && !s_ff.runWhileHalted);

    // conversion sequence
    unique case (s_ff.state)
      ST_IDLE: begin
        if (startReq && canStart) begin
          nxt_s.count = 9'd0;
          nxt_s.state = keep_analog_powered ? ST_CONV : ST_WARM;
        end
      end
      ST_WARM: begin
        if (s_ff.count >= 9'(WARMUP_CYCLES - 1)) begin
          nxt_s.count = 9'd0;
          nxt_s.state = ST_CONV;
        end else begin
          nxt_s.count = s_ff.count + 9'd1;
        end
      end
      ST_CONV: begin
        if (convTick) begin
          nxt_s.count = s_ff.count + 9'd1;
          if (s_ff.count >= {1'b0, s_ff.sampDur} + CONV_BASE_TICKS) begin
            nxt_s.state = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        // capture: sample, result, overwrite and window flags
        nxt_s.state = ST_IDLE;
        nxt_s.sample = newSample;
        nxt_s.result = {16'h0000, newSample};
        nxt_s.sampUnread = 1'b1;
        nxt_s.resUnread = 1'b1;
        setFlags[FLG_SAMPLE_READY] = 1'b1;
        setFlags[FLG_RESULT_READY] = 1'b1;
        setFlags[FLG_SAMPLE_OVERWRITE] = s_ff.sampUnread;
        setFlags[FLG_RESULT_OVERWRITE] = s_ff.resUnread;
        winSrc = newSample;
        setFlags[FLG_WINDOW_MATCH] = windowHit(s_ff.winCtl, winSrc, s_ff.winLow, s_ff.winHigh);
        nxt_s.evRes = 1'b1;
        nxt_s.evSamp = 1'b1;
        nxt_s.evWin = setFlags[FLG_WINDOW_MATCH];
      end
    endcase

    // a trigger while busy is an overrun
    if (startReq && s_ff.state != ST_IDLE) begin
      setFlags[FLG_TRIGGER_OVERRUN] = 1'b1;
    end

    // power-down or disable aborts at once; standby or halt lets it finish
    if (powerDown || !nxt_s.controlA[BIT_ENABLE]) begin
      nxt_s.state = ST_IDLE;
      nxt_s.count = 9'd0;
    end

    // flags: an event in the clearing cycle survives
    nxt_s.irqFlags = (s_ff.irqFlags & ~clrFlags) | setFlags;
    nxt_s.irq = |(nxt_s.irqFlags & nxt_s.irqEn);

    // analog power policy
    if (!nxt_s.controlA[BIT_ENABLE] || powerDown) begin
      nxt_s.analogPwr = 1'b0;
    end else if (nxt_s.controlA[BIT_KEEP_ANALOG_POWERED]) begin
      nxt_s.analogPwr = !standbySleep || nxt_s.controlA[BIT_RUN_IN_STANDBY]
                        || (nxt_s.state != ST_IDLE);
    end else begin
      nxt_s.analogPwr = (nxt_s.state != ST_IDLE);
    end

    // main clock request in standby, registered state decodes for the outputs
    nxt_s.mainReq = standbySleep && runStd && (nxt_s.state != ST_IDLE);
    nxt_s.convRun = (nxt_s.state == ST_CONV);
    nxt_s.busy = (nxt_s.state != ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from the state register, both response codes fixed at okay
  assign s_axi_awready = s_ff.awRdy;
  assign s_axi_wready = s_ff.wRdy;
  assign s_axi_bresp = 2'h0;
  assign s_axi_bvalid = s_ff.bValid;
  assign s_axi_arready = s_ff.arRdy;
  assign s_axi_rdata = s_ff.rData;
  assign s_axi_rresp = 2'h0;
  assign s_axi_rvalid = s_ff.rValid;
  assign analogPowerOn = s_ff.analogPwr;
  assign mainClockRequest = s_ff.mainReq;
  assign convClockRun = s_ff.convRun;
  assign conversionInProgress = s_ff.busy;
  assign refSelect = s_ff.refSel;
  assign ampControl = s_ff.amp;
  assign posInputSelect = s_ff.positive_input_select;
  assign negInputSelect = s_ff.negative_input_select;
  assign evResultReady = s_ff.evRes;
  assign evSampleReady = s_ff.evSamp;
  assign evWindowMatch = s_ff.evWin;
  assign irq = s_ff.irq;
endmodule // adcc_control_bank

// [dv/adcc_control_bank_asserts.sv]
`timescale 1ns/1ps
module adcc_control_bank_chk #(
  parameter int ADDR_W = 7
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic standbySleep,
  input wire logic powerDown,
  input wire logic analogPowerOn,
  input wire logic mainClockRequest,
  input wire logic convClockRun,
  input wire logic conversionInProgress,
  input wire logic evResultReady,
  input wire logic irq
);
  // all checks on the peripheral clock, quiet during reset except the reset-state check
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_clock_idle;
    !conversionInProgress |-> !convClockRun;
  endproperty
  a_clock_idle: assert property (p_clock_idle)
    else $error("converter clock runs while idle");
  property p_warmup;
    $rose(conversionInProgress) && !$past(analogPowerOn) |-> !convClockRun [*8];
  endproperty
  a_warmup: assert property (p_warmup)
    else $error("conversion started without warm-up");
  property p_powered_conv;
    convClockRun |-> analogPowerOn;
  endproperty
  a_powered_conv: assert property (p_powered_conv)
    else $error("converting with analog power off");
  property p_fast_start;
    $rose(conversionInProgress) && $past(analogPowerOn) |-> ##[0:2] convClockRun;
  endproperty
  a_fast_start: assert property (p_fast_start)
    else $error("powered start was slow");
  property p_clk_request;
    mainClockRequest |-> (standbySleep || $past(standbySleep))
      && (conversionInProgress || $past(conversionInProgress));
  endproperty
  a_clk_request: assert property (p_clk_request)
    else $error("clock request outside standby conversion");
  property p_abort;
    powerDown |=> !conversionInProgress;
  endproperty
  a_abort: assert property (p_abort)
    else $error("conversion kept in power down");
  property p_reset_state;
    disable iff (1'b0)
    !nrst |=> !conversionInProgress && !irq && !analogPowerOn && !mainClockRequest;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("outputs not cleared by reset");
  property p_unmapped_zero;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[ADDR_W-1:2] inside
      {5'h0E, 5'h0F, 5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h17, 5'h1B, 5'h1D, 5'h1F})
      |=> s_axi_rvalid && s_axi_rdata == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("reserved read not zero");
  property p_bresp_okay;
    s_axi_bvalid |-> s_axi_bresp == 2'b00;
  endproperty
  a_bresp_okay: assert property (p_bresp_okay)
    else $error("write response not okay");
  property p_result_pulse;
    evResultReady |-> $past(conversionInProgress) ##1 !evResultReady;
  endproperty
  a_result_pulse: assert property (p_result_pulse)
    else $error("result event not a single pulse after a conversion");
  property p_rvalid_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped before taken");
endmodule // adcc_control_bank_chk

// [dv/test_adc_control_register_bank.sv]
`timescale 1ns/1ps
module test_adc_control_register_bank;
  import adcc_pkg::*;
  localparam int ADDR_W = 7;
  logic clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic startEvent, standbySleep, powerDown, debugHalt;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [15:0] analogSample;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic analogPowerOn, mainClockRequest, convClockRun, conversionInProgress, irq;
  logic evResultReady, evSampleReady, evWindowMatch;
  logic [2:0] refSelect;
  logic [7:0] ampControl, posInputSelect, negInputSelect;
  int mismatches = 0;
  int compares = 0;
  int idleBusy = 0;
  int divs[16] = '{2, 4, 6, 8, 10, 12, 14, 16, 20, 24, 28, 32, 40, 48, 56, 64};

  adcc_control_bank #(.ADDR_W(ADDR_W)) u_adcc_control_bank (.*);

  // 20 MHz clock
  always #25 clk = ~clk;

  // counts busy cycles without converter clock (warm-up plus finish)
  always @(posedge clk) if (conversionInProgress === 1'b1 && convClockRun !== 1'b1) idleBusy++;

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic bump(inout int n);
    n++;
    if (n > 3000) begin
      mismatches++;
      $display("Error at %0t: wait limit reached", $time);
      summarize();
    end
  endtask

  // bus write: hold each channel until taken, then wait for the response
  task automatic axWrite(input logic [4:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
      bump(n);
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axRead(input logic [4:0] idx, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
      bump(n);
    end
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask

  task automatic readCheck(input logic [4:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    axRead(idx, d);
    check(d, exp);
  endtask

  // waits for the running conversion to end, counting peripheral clock cycles with the converter clock running
  task automatic runConv(output int len);
    int n;
    n = 0;
    len = 0;
    forever begin
      @(posedge clk);
      if (convClockRun === 1'b1) len++;
      if (conversionInProgress !== 1'b1 && n > 3) break;
      bump(n);
    end
  endtask

  task automatic pulseEvent();
    @(posedge clk);
    startEvent <= 1'b1;
    repeat (8) @(posedge clk);
    startEvent <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  task automatic testRegs();
    logic [4:0] idx[6] = '{IDX_CONTROL_A, IDX_CLOCK_DIVIDER_CONTROL, IDX_IRQ_ENABLE,
      IDX_IRQ_FLAGS, IDX_CONVERTER_STATUS, 5'h0E};
    foreach (idx[i]) readCheck(idx[i], 32'h0);
    axWrite(IDX_CONTROL_A, 32'hFF);
    readCheck(IDX_CONTROL_A, 32'hA1);
    check(32'(analogPowerOn), 32'h1);
    axWrite(5'h0E, 32'hFF);
    readCheck(5'h0E, 32'h0);
    readCheck(5'h1D, 32'h0);
    axWrite(IDX_CONVERTER_STATUS, 32'hFF);
    axWrite(IDX_REFERENCE_CONTROL, 32'hFF);
    readCheck(IDX_REFERENCE_CONTROL, 32'h07);
    check(32'(refSelect), 32'h7);
    axWrite(IDX_CONTROL_A, 32'h00);
    readCheck(IDX_CONVERTER_STATUS, 32'h0);
    check(32'(analogPowerOn), 32'h0);
  endtask

  task automatic testPresc();
    int len;
    axWrite(IDX_CONTROL_A, 32'h21);
    for (int c = 0; c < 16; c++) begin
      axWrite(IDX_CLOCK_DIVIDER_CONTROL, 32'(c));
      idleBusy = 0;
      axWrite(IDX_CONVERSION_COMMAND, 32'(START_IMMEDIATE));
      runConv(len);
      check(32'(len >= 12 * divs[c] && len <= 14 * divs[c] + 2), 32'h1);
      check(32'(idleBusy <= 2), 32'h1);
    end
    check(32'(analogPowerOn), 32'h1);
    check(32'(convClockRun), 32'h0);
  endtask

  task automatic testLowLat();
    int len;
    axWrite(IDX_CONTROL_A, 32'h01);
    axWrite(IDX_CLOCK_DIVIDER_CONTROL, 32'h0);
    check(32'(analogPowerOn), 32'h0);
    idleBusy = 0;
    axWrite(IDX_CONVERSION_COMMAND, 32'(START_IMMEDIATE));
    runConv(len);
    check(32'(idleBusy), 32'(WARMUP_CYCLES + 1));
    readCheck(IDX_CONVERTER_STATUS, 32'h0);
    check(32'(analogPowerOn), 32'h0);
  endtask

  task automatic testIrq();
    logic [31:0] d;
    int len;
    analogSample <= 16'hA5C3;
    axWrite(IDX_CONTROL_A, 32'h21);
    axRead(IDX_CONVERSION_RESULT, d);
    axRead(IDX_LAST_SAMPLE, d);
    axWrite(IDX_IRQ_FLAGS, 32'h3F);
    axWrite(IDX_IRQ_ENABLE, 32'h01);
    axWrite(IDX_WINDOW_CONTROL, 32'(WIN_ABOVE));
    axWrite(IDX_CONVERSION_COMMAND, 32'(START_IMMEDIATE));
    runConv(len);
    readCheck(IDX_IRQ_FLAGS, 32'h07);
    check(32'(irq), 32'h1);
    readCheck(IDX_CONVERSION_RESULT, 32'h0000A5C3);
    readCheck(IDX_LAST_SAMPLE, 32'h0000A5C3);
    axWrite(IDX_IRQ_FLAGS, 32'h00);
    readCheck(IDX_IRQ_FLAGS, 32'h07);
    axWrite(IDX_IRQ_FLAGS, 32'h02);
    readCheck(IDX_IRQ_FLAGS, 32'h05);
    axWrite(IDX_IRQ_ENABLE, 32'h02);
    readCheck(IDX_IRQ_ENABLE, 32'h02);
    check(32'(irq), 32'h0);
    axWrite(IDX_IRQ_FLAGS, 32'h05);
    readCheck(IDX_IRQ_FLAGS, 32'h00);
  endtask

  // second start while busy is refused and flagged
  task automatic testOverrun();
    int len;
    axWrite(IDX_CLOCK_DIVIDER_CONTROL, 32'h0F);
    axWrite(IDX_CONVERSION_COMMAND, 32'(START_ON_EVENT));
    check(32'(conversionInProgress), 32'h0);
    pulseEvent();
    check(32'(conversionInProgress), 32'h1);
    pulseEvent();
    runConv(len);
    readCheck(IDX_IRQ_FLAGS, 32'h27);
  endtask

  task automatic testStandby();
    int len;
    axWrite(IDX_CLOCK_DIVIDER_CONTROL, 32'h00);
    axWrite(IDX_CONTROL_A, 32'h01);
    axWrite(IDX_IRQ_FLAGS, 32'h3F);
    standbySleep <= 1'b1;
    axWrite(IDX_CONVERSION_COMMAND, 32'(START_IMMEDIATE));
    readCheck(IDX_CONVERTER_STATUS, 32'h0);
    standbySleep <= 1'b0;
    axWrite(IDX_CONVERSION_COMMAND, 32'(START_IMMEDIATE));
    standbySleep <= 1'b1;
    runConv(len);
    readCheck(IDX_IRQ_FLAGS, 32'h1F);
    axWrite(IDX_CONTROL_A, 32'hA1);
    axWrite(IDX_IRQ_FLAGS, 32'h3F);
    check(32'(analogPowerOn), 32'h1);
    axWrite(IDX_CONVERSION_COMMAND, 32'(START_IMMEDIATE));
    repeat (3) @(posedge clk);
    check(32'(mainClockRequest), 32'h1);
    runConv(len);
    standbySleep <= 1'b0;
    axWrite(IDX_IRQ_FLAGS, 32'h3F);
    axWrite(IDX_CONVERSION_COMMAND, 32'(START_IMMEDIATE));
    powerDown <= 1'b1;
    readCheck(IDX_CONVERTER_STATUS, 32'h0);
    powerDown <= 1'b0;
    readCheck(IDX_IRQ_FLAGS, 32'h00);
  endtask

  // main sequence
  initial begin
    {clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {startEvent, standbySleep, powerDown, debugHalt, analogSample} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    testRegs();
    testPresc();
    testLowLat();
    testIrq();
    testOverrun();
    testStandby();
    summarize();
  end
endmodule // test_adc_control_register_bank

bind adcc_control_bank adcc_control_bank_chk #(.ADDR_W(ADDR_W)) u_adcc_control_bank_chk (.*);
